// File: hw/pin_port_defs.svh
`ifndef PIN_PORT_DEFS_SVH
`define PIN_PORT_DEFS_SVH

// register offsets inside the memory mapped config space
`define PIN_DIR_LOW_OFS   12'h0c2a
`define PIN_DIR_HIGH_OFS  12'h0c2c
`define PIN_LEVEL_LOW_OFS 12'h0c30
`define PIN_LEVEL_HIGH_OFS 12'h0c32
`define PIN_SET_LOW_OFS   12'h0c34
`define PIN_SET_HIGH_OFS  12'h0c36
`define PIN_CLR_LOW_OFS   12'h0c38
`define PIN_CLR_HIGH_OFS  12'h0c3a

// distance from a lower half register to its upper half
`define PIN_HALF_STEP     12'h0002

// widths and reset values
`define PIN_COUNT         32
`define PIN_HALF_W        16
`define PIN_DIR_RST       16'h0000
`define PIN_LEVEL_RST     16'h0000
`define PIN_HALF_ZERO     16'h0000

`endif

// File: hw/pin_port_pkg.sv
package pin_port_pkg;

    typedef enum logic {
        ACC_IDLE,
        ACC_UPPER
    } access_state_t;

endpackage

// File: hw/level_sync.sv
`timescale 1ns/10ps

module level_sync #(
    parameter int WIDTH = 32
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_r;

    // first stage feeds only the second stage
    always_ff @(posedge clock) begin
        if (!rstn) begin
            stage1_r <= '0;
            sync_out <= '0;
        end else begin
            stage1_r <= async_in;
            sync_out <= stage1_r;
        end
    end

endmodule // level_sync

// File: hw/programmable_pin_dir_data.sv
`timescale 1ns/10ps

`include "pin_port_defs.svh"

module programmable_pin_dir_data
    import pin_port_pkg::*;
#(
    parameter int PINS = `PIN_COUNT
) (
    input  wire logic [11:0]     cfg_addr,
    input  wire logic            cfg_sel,
    input  wire logic            cfg_write,
    input  wire logic            cfg_wide,
    input  wire logic [31:0]     cfg_wdata,
    output logic      [31:0]     cfg_rdata,
    output logic                 cfg_done,
    output logic                 cfg_busy,
    input  wire logic [PINS-1:0] pin_function_select_bit,
    input  wire logic [PINS-1:0] alt_out,
    input  wire logic [PINS-1:0] alt_oe,
    input  wire logic [PINS-1:0] pin_in,
    output logic      [PINS-1:0] pin_out,
    output logic      [PINS-1:0] pin_oe,
    input  wire logic            clock,
    input  wire logic            rstn
);

    localparam int HW = `PIN_HALF_W;

    access_state_t   state_r;
    logic [11:0]     hold_addr_r;
    logic [HW-1:0]   hold_wdata_r;
    logic            hold_write_r;
    logic [PINS-1:0] pin_direction_bit_r;
    logic [PINS-1:0] latch_r;
    logic [PINS-1:0] pin_level_s;

    function automatic logic is_lower_half(input logic [11:0] addr);
        is_lower_half = (addr == `PIN_DIR_LOW_OFS) || (addr == `PIN_LEVEL_LOW_OFS) ||
                        (addr == `PIN_SET_LOW_OFS) || (addr == `PIN_CLR_LOW_OFS);
    endfunction

    // one half of the output latch: data write, set and clear all land here
    function automatic logic [HW-1:0] half_latch(
        input logic [HW-1:0] old,
        input logic [HW-1:0] wd,
        input logic [HW-1:0] ok,
        input logic          lvl,
        input logic          set,
        input logic          clr
    );
        half_latch = old;
        if (lvl) begin
            half_latch = wd;
        end else if (set) begin
            half_latch = old | (wd & ok);
        end else if (clr) begin
            half_latch = old & ~(wd & ok);
        end
    endfunction

    level_sync #(
        .WIDTH (PINS)
    ) u_pin_sync (
        .clock    (clock),
        .rstn     (rstn),
        .async_in (pin_in),
        .sync_out (pin_level_s)
    );

    // current half-word access
    wire            take      = cfg_sel && (state_r == ACC_IDLE);
    wire            upper     = (state_r == ACC_UPPER);
    wire            active    = take || upper;
    wire            split     = take && cfg_wide && is_lower_half(cfg_addr);
    wire [11:0]     cur_addr  = upper ? hold_addr_r : cfg_addr;
    wire [HW-1:0]   cur_wdata = upper ? hold_wdata_r : cfg_wdata[HW-1:0];
    wire            cur_wr    = active && (upper ? hold_write_r : cfg_write);

    wire            hit_dir_lo = cur_addr == `PIN_DIR_LOW_OFS;
    wire            hit_dir_hi = cur_addr == `PIN_DIR_HIGH_OFS;
    wire            hit_lvl_lo = cur_addr == `PIN_LEVEL_LOW_OFS;
    wire            hit_lvl_hi = cur_addr == `PIN_LEVEL_HIGH_OFS;
    wire            hit_set_lo = cur_addr == `PIN_SET_LOW_OFS;
    wire            hit_set_hi = cur_addr == `PIN_SET_HIGH_OFS;
    wire            hit_clr_lo = cur_addr == `PIN_CLR_LOW_OFS;
    wire            hit_clr_hi = cur_addr == `PIN_CLR_HIGH_OFS;

    // pins that software may drive: output and not given to the interface function
    wire [PINS-1:0] drive_ok = pin_direction_bit_r & ~pin_function_select_bit;

    // driven pins read the latch, all others the sampled pin
    wire [PINS-1:0] pin_read = (drive_ok & latch_r) | (~drive_ok & pin_level_s);

    wire [HW-1:0]   dir_lo_nxt = (cur_wr && hit_dir_lo) ? cur_wdata
                                 : pin_direction_bit_r[HW-1:0];
    wire [HW-1:0]   dir_hi_nxt = (cur_wr && hit_dir_hi) ? cur_wdata
                                 : pin_direction_bit_r[PINS-1:HW];

    wire [HW-1:0]   latch_lo_nxt = half_latch(latch_r[HW-1:0], cur_wdata, drive_ok[HW-1:0],
                                              cur_wr && hit_lvl_lo, cur_wr && hit_set_lo,
                                              cur_wr && hit_clr_lo);
    wire [HW-1:0]   latch_hi_nxt = half_latch(latch_r[PINS-1:HW], cur_wdata,
                                              drive_ok[PINS-1:HW], cur_wr && hit_lvl_hi,
                                              cur_wr && hit_set_hi, cur_wr && hit_clr_hi);

    wire [HW-1:0]   rd_half = hit_dir_lo ? pin_direction_bit_r[HW-1:0]
                            : hit_dir_hi ? pin_direction_bit_r[PINS-1:HW]
                            : hit_lvl_lo ? pin_read[HW-1:0]
                            : hit_lvl_hi ? pin_read[PINS-1:HW]
                            : `PIN_HALF_ZERO;

    // pad controls: interface function first, then direction and latch
    wire [PINS-1:0] oe_nxt  = (pin_function_select_bit & alt_oe) | drive_ok;
    wire [PINS-1:0] out_nxt = (pin_function_select_bit & alt_out) |
                              (~pin_function_select_bit & latch_r);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pin_direction_bit_r <= {2{`PIN_DIR_RST}};
            latch_r             <= {2{`PIN_LEVEL_RST}};
            pin_oe              <= '0;
            pin_out             <= '0;
        end else begin
            pin_direction_bit_r <= {dir_hi_nxt, dir_lo_nxt};
            latch_r             <= {latch_hi_nxt, latch_lo_nxt};
            pin_oe              <= oe_nxt;
            pin_out             <= out_nxt;
        end
    end

    // access sequencer: a wide access to a lower half register takes the low half first, the high half next
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_r      <= ACC_IDLE;
            hold_addr_r  <= 12'h0000;
            hold_wdata_r <= `PIN_HALF_ZERO;
            hold_write_r <= 1'b0;
            cfg_rdata    <= 32'h0000_0000;
            cfg_done     <= 1'b0;
            cfg_busy     <= 1'b0;
        end else begin
            cfg_done <= 1'b0;
            case (state_r)
                ACC_IDLE: begin
                    if (take) begin
                        cfg_rdata    <= {`PIN_HALF_ZERO, rd_half};
                        hold_addr_r  <= cfg_addr + `PIN_HALF_STEP;
                        hold_wdata_r <= cfg_wdata[31:HW];
                        hold_write_r <= cfg_write;
                        if (split) begin
                            state_r  <= ACC_UPPER;
                            cfg_busy <= 1'b1;
                        end else begin
                            cfg_done <= 1'b1;
                        end
                    end
                end
                ACC_UPPER: begin
                    cfg_rdata[31:HW] <= rd_half;
                    state_r          <= ACC_IDLE;
                    cfg_busy         <= 1'b0;
                    cfg_done         <= 1'b1;
                end
                default: begin
                    state_r  <= ACC_IDLE;
                    cfg_busy <= 1'b0;
                end
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    dir_reset_a: assert property (disable iff (1'b0)
        !rstn |=> (pin_direction_bit_r == '0) && (pin_oe == '0))
        else $error("direction or driver not cleared by reset");

    dir_low_pin_a: assert property (
        (take && cfg_write && !cfg_wide && cfg_addr == `PIN_DIR_LOW_OFS &&
         pin_function_select_bit[HW-1:0] == '0) ##1
        (pin_function_select_bit[HW-1:0] == '0)
        |=> pin_oe[HW-1:0] == $past(cfg_wdata[HW-1:0], 2))
        else $error("lower direction write not seen on drivers");

    dir_high_pin_a: assert property (
        (take && cfg_write && !cfg_wide && cfg_addr == `PIN_DIR_HIGH_OFS &&
         pin_function_select_bit[PINS-1:HW] == '0) ##1
        (pin_function_select_bit[PINS-1:HW] == '0)
        |=> pin_oe[PINS-1:HW] == $past(cfg_wdata[HW-1:0], 2))
        else $error("upper direction write not seen on drivers");

    func_override_a: assert property (
        ##1 ((pin_oe & $past(pin_function_select_bit)) ==
             ($past(alt_oe) & $past(pin_function_select_bit))))
        else $error("function pin not following interface function");

    input_quiet_a: assert property (
        ##1 ((pin_oe & ~$past(pin_function_select_bit) & ~$past(pin_direction_bit_r)) == '0))
        else $error("input pin driver enabled");

    dir_split_a: assert property (
        (take && cfg_wide && cfg_addr == `PIN_DIR_LOW_OFS)
        |=> (cfg_busy && !cfg_done) ##1 (cfg_done && !cfg_busy))
        else $error("wide direction access not split in two");

    data_order_a: assert property (
        (take && cfg_write && cfg_wide && cfg_addr == `PIN_LEVEL_LOW_OFS)
        |=> (latch_r[HW-1:0] == $past(cfg_wdata[HW-1:0]) &&
             latch_r[PINS-1:HW] == $past(latch_r[PINS-1:HW]))
        ##1 (latch_r[PINS-1:HW] == $past(cfg_wdata[31:HW], 2)))
        else $error("wide data write halves out of order");

    set_drive_a: assert property (
        (take && cfg_write && !cfg_wide && cfg_addr == `PIN_SET_LOW_OFS)
        |=> ((latch_r[HW-1:0] & $past(cfg_wdata[HW-1:0] & drive_ok[HW-1:0])) ==
             $past(cfg_wdata[HW-1:0] & drive_ok[HW-1:0])) &&
            ((latch_r[HW-1:0] & ~$past(drive_ok[HW-1:0])) ==
             ($past(latch_r[HW-1:0]) & ~$past(drive_ok[HW-1:0]))))
        else $error("set write wrong on driven or undriven pins");

    func_read_a: assert property (
        (take && !cfg_write && !cfg_wide && cfg_addr == `PIN_LEVEL_LOW_OFS &&
         pin_function_select_bit[HW-1:0] == '1)
        |=> cfg_done && cfg_rdata[HW-1:0] == $past(pin_level_s[HW-1:0]))
        else $error("data read not returning pin level");

    out_read_a: assert property (
        (take && cfg_write && !cfg_wide && cfg_addr == `PIN_LEVEL_HIGH_OFS &&
         drive_ok[PINS-1:HW] == '1) ##1
        (take && !cfg_write && !cfg_wide && cfg_addr == `PIN_LEVEL_HIGH_OFS &&
         drive_ok[PINS-1:HW] == '1)
        |=> cfg_rdata[HW-1:0] == $past(cfg_wdata[HW-1:0], 2) &&
            pin_out[PINS-1:HW] == $past(cfg_wdata[HW-1:0], 2))
        else $error("output pin not returning programmed level");

    latch_reset_a: assert property (disable iff (1'b0)
        !rstn |=> (latch_r == '0) && (pin_out == '0) && !cfg_done && !cfg_busy)
        else $error("latch or bus outputs not cleared by reset");

    level_high_a: assert property (
        (take && cfg_write && !cfg_wide && cfg_addr == `PIN_LEVEL_HIGH_OFS)
        |=> latch_r[PINS-1:HW] == $past(cfg_wdata[HW-1:0]))
        else $error("upper data write not stored");

    wide_read_a: assert property (
        (take && !cfg_write && cfg_wide && cfg_addr == `PIN_LEVEL_LOW_OFS)
        |=> (cfg_busy && cfg_rdata[HW-1:0] == $past(pin_read[HW-1:0]))
        ##1 (cfg_done && cfg_rdata[31:HW] == $past(pin_read[PINS-1:HW]) &&
             cfg_rdata[HW-1:0] == $past(cfg_rdata[HW-1:0])))
        else $error("wide data read halves out of order");

    narrow_zero_a: assert property (
        (take && !cfg_write && !cfg_wide)
        |=> cfg_done && cfg_rdata[31:HW] == '0)
        else $error("half word read returned upper bits");

    dir_order_a: assert property (
        (take && cfg_write && cfg_wide && cfg_addr == `PIN_DIR_LOW_OFS)
        |=> (pin_direction_bit_r[HW-1:0] == $past(cfg_wdata[HW-1:0]) &&
             pin_direction_bit_r[PINS-1:HW] == $past(pin_direction_bit_r[PINS-1:HW]))
        ##1 (pin_direction_bit_r[PINS-1:HW] == $past(cfg_wdata[31:HW], 2)))
        else $error("wide direction write halves out of order");

    dir_read_a: assert property (
        (take && !cfg_write && !cfg_wide && cfg_addr == `PIN_DIR_LOW_OFS)
        |=> cfg_rdata[HW-1:0] == $past(pin_direction_bit_r[HW-1:0]))
        else $error("lower direction read wrong");

    oe_dir_a: assert property (
        ##1 ((pin_oe & ~$past(pin_function_select_bit)) ==
             ($past(pin_direction_bit_r) & ~$past(pin_function_select_bit))))
        else $error("driver enable not following direction");

    out_latch_a: assert property (
        ##1 ((pin_out & ~$past(pin_function_select_bit)) ==
             ($past(latch_r) & ~$past(pin_function_select_bit))))
        else $error("pin level not following output latch");

    func_out_a: assert property (
        ##1 ((pin_out & $past(pin_function_select_bit)) ==
             ($past(alt_out) & $past(pin_function_select_bit))))
        else $error("function pin level not from interface function");

    clr_drive_a: assert property (
        (take && cfg_write && !cfg_wide && cfg_addr == `PIN_CLR_LOW_OFS)
        |=> latch_r[HW-1:0] ==
            ($past(latch_r[HW-1:0]) & ~$past(cfg_wdata[HW-1:0] & drive_ok[HW-1:0])))
        else $error("clear write wrong on driven or undriven pins");

endmodule // programmable_pin_dir_data

// File: verification/pin_partner.sv
`timescale 1ns/10ps
module pin_partner (
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] ext_level,
    output logic      [31:0] pin_in
);
    // a released pin shows the external level, a driven one its own
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pin_partner

// File: verification/programmable_pin_dir_data_tb.sv
`timescale 1ns/10ps
module programmable_pin_dir_data_tb;
    localparam logic [31:0] DIR_V = 32'ha5a5_0f0f;
    localparam logic [31:0] LAT_V = 32'h1234_5678;
    localparam logic [31:0] EXT_V = 32'h3c3c_3c3c;
    logic        clock, rstn, cfg_sel, cfg_write, cfg_wide, cfg_done, cfg_busy, busy_seen;
    logic [11:0] cfg_addr;
    logic [31:0] cfg_wdata, cfg_rdata, fnc, alt_out, alt_oe, pin_in, pin_out, pin_oe, rd;
    int          n_fail, checks_done;

    programmable_pin_dir_data dut (
        .cfg_addr(cfg_addr), .cfg_sel(cfg_sel), .cfg_write(cfg_write),
        .cfg_wide(cfg_wide), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_done(cfg_done), .cfg_busy(cfg_busy), .pin_function_select_bit(fnc),
        .alt_out(alt_out), .alt_oe(alt_oe), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .clock(clock), .rstn(rstn)
    );
    pin_partner far_side (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(EXT_V), .pin_in(pin_in)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // one request, held for one clock, then wait for done
    task automatic bus(input logic [11:0] a, input logic w, input logic wd,
                       input logic [31:0] d);
        int i;
        @(posedge clock);
        cfg_sel <= 1'b1;
        cfg_addr <= a;
        cfg_write <= w;
        cfg_wide <= wd;
        cfg_wdata <= d;
        @(posedge clock);
        cfg_sel <= 1'b0;
        #1;
        i = 0;
        busy_seen = 1'b0;
        while (cfg_done !== 1'b1) begin
            if (cfg_busy === 1'b1) busy_seen = 1'b1;
            i++;
            if (i > 6) begin
                n_fail++;
                finish_test();
            end
            @(posedge clock);
            #1;
        end
        rd = cfg_rdata;
    endtask

    task automatic settle;
        repeat (4) @(posedge clock);
        #1;
    endtask

    task automatic t_reset;
        bus(12'h0c2a, 1'b0, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        bus(12'h0c2c, 1'b0, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(pin_oe, 32'h0000_0000);
        bus(12'h0c40, 1'b0, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_dir;
        bus(12'h0c2a, 1'b1, 1'b1, DIR_V);
        chk({31'h0000_0000, busy_seen}, 32'h0000_0001);
        bus(12'h0c2a, 1'b0, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_0f0f);
        bus(12'h0c2c, 1'b0, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_a5a5);
        bus(12'h0c2a, 1'b0, 1'b1, 32'h0000_0000);
        chk(rd, DIR_V);
        settle();
        chk(pin_oe, DIR_V);
        $display("test direction done");
    endtask

    task automatic t_data;
        bus(12'h0c30, 1'b1, 1'b1, LAT_V);
        chk({31'h0000_0000, busy_seen}, 32'h0000_0001);
        settle();
        chk(pin_out, LAT_V);
        bus(12'h0c30, 1'b0, 1'b1, 32'h0000_0000);
        chk(rd, (LAT_V & DIR_V) | (EXT_V & ~DIR_V));
        $display("test data done");
    endtask

    task automatic t_setclr;
        bus(12'h0c34, 1'b1, 1'b1, 32'hffff_ffff);
        settle();
        chk(pin_out, LAT_V | DIR_V);
        bus(12'h0c2a, 1'b1, 1'b1, 32'hffff_ffff);
        settle();
        chk(pin_out, LAT_V | DIR_V);
        bus(12'h0c38, 1'b1, 1'b1, 32'hffff_ffff);
        settle();
        chk(pin_out, 32'h0000_0000);
        $display("test set clear done");
    endtask

    task automatic t_fnc;
        @(posedge clock);
        fnc <= 32'hffff_0000;
        alt_out <= 32'h6666_0000;
        alt_oe <= 32'hf0f0_0000;
        settle();
        chk(pin_oe, 32'hf0f0_ffff);
        chk(pin_out, 32'h6666_0000);
        bus(12'h0c30, 1'b0, 1'b1, 32'h0000_0000);
        chk(rd, 32'h6c6c_0000);
        bus(12'h0c2a, 1'b1, 1'b1, 32'h0000_0000);
        settle();
        chk(pin_oe, 32'hf0f0_0000);
        @(posedge clock);
        fnc <= 32'h0000_ffff;
        settle();
        bus(12'h0c30, 1'b0, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_3c3c);
        $display("test function done");
    endtask

    // half-word accesses, then a write and a read taken on back to back edges
    task automatic t_narrow;
        @(posedge clock);
        fnc <= 32'h0000_0000;
        bus(12'h0c2a, 1'b1, 1'b0, 32'h0000_00ff);
        bus(12'h0c2c, 1'b1, 1'b0, 32'h0000_ffff);
        settle();
        chk(pin_oe, 32'hffff_00ff);
        bus(12'h0c34, 1'b1, 1'b0, 32'h0000_ffff);
        settle();
        chk(pin_out, 32'h0000_00ff);
        bus(12'h0c38, 1'b1, 1'b0, 32'h0000_000f);
        settle();
        chk(pin_out, 32'h0000_00f0);
        bus(12'h0c30, 1'b0, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_3cf0);
        @(posedge clock);
        cfg_sel <= 1'b1;
        cfg_addr <= 12'h0c32;
        cfg_write <= 1'b1;
        cfg_wide <= 1'b0;
        cfg_wdata <= 32'h0000_9a9a;
        @(posedge clock);
        cfg_write <= 1'b0;
        @(posedge clock);
        cfg_sel <= 1'b0;
        #1;
        chk({31'h0000_0000, cfg_done}, 32'h0000_0001);
        chk(cfg_rdata, 32'h0000_9a9a);
        settle();
        chk(pin_out, 32'h9a9a_00f0);
        $display("test narrow done");
    endtask

    initial begin
        n_fail = 0;
        checks_done = 0;
        rstn = 1'b0;
        cfg_sel = 1'b0;
        cfg_write = 1'b0;
        cfg_wide = 1'b0;
        cfg_addr = 12'h000;
        cfg_wdata = 32'h0000_0000;
        fnc = 32'h0000_0000;
        alt_out = 32'h0000_0000;
        alt_oe = 32'h0000_0000;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        t_reset();
        t_dir();
        t_data();
        t_setclr();
        t_fnc();
        t_narrow();
        finish_test();
    end
endmodule // programmable_pin_dir_data_tb
